// File: nfc_ctrl_pkg.sv
// constants shared by both ends of the tag control link
// assumes a single 200 MHz clock on both ends
package nfc_ctrl_pkg;
   // ****************************************
   // device register map, byte addresses
   // ****************************************
   localparam logic [15:0] CTRL_ADDR = 16'hFFFE;
   localparam logic [15:0] CTRL_HI_ADDR = 16'hFFFF;
   localparam logic [15:0] IEN_ADDR = 16'hFFFA;
   localparam logic [15:0] FLAG_ADDR = 16'hFFF8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] IEN_RESET = 8'h00;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   // general control fields
   localparam int RESTART_BIT = 0;
   localparam int RADIO_BIT = 1;
   localparam int INTEN_BIT = 2;
   localparam int POLHIGH_BIT = 3;
   localparam int PUSHPULL_BIT = 4;
   localparam int BIP_BIT = 5;
   localparam int STANDBY_BIT = 6;
   // interrupt flag / enable fields
   localparam int IRQ_BIP_BIT = 4;
   localparam int IRQ_NDEF_BIT = 5;
   // ****************************************
   // frame commands and byte positions
   // ****************************************
   localparam logic [7:0] CMD_WRITE = 8'h02;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_READ_ALT = 8'h0B;
   localparam logic [7:0] DUMMY_BYTE = 8'h00;
   localparam logic [2:0] IDX_CMD = 3'h0;
   localparam logic [2:0] IDX_AHI = 3'h1;
   localparam logic [2:0] IDX_ALO = 3'h2;
   localparam logic [2:0] IDX_D0 = 3'h3;
   localparam logic [2:0] IDX_D1 = 3'h4;
   localparam logic [2:0] IDX_CHK = 3'h5;
   localparam logic [2:0] IDX_LAST = 3'h7;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 200;
   localparam int RESTART_NS = 1000;
   localparam int RESTART_CYCLES = (RESTART_NS * CLK_MHZ + 999) / 1000;
   // ****************************************
   // host controller register map
   // ****************************************
   localparam logic [3:0] H_ADDR = 4'h0;
   localparam logic [3:0] H_WDATA = 4'h1;
   localparam logic [3:0] H_CMD = 4'h2;
   localparam logic [3:0] H_STAT = 4'h3;
   localparam logic [3:0] H_RDATA = 4'h4;
   localparam logic [3:0] H_IRQST = 4'h5;
   localparam logic [3:0] H_IRQCLR = 4'h6;
   localparam logic [3:0] H_IRQEN = 4'h7;
   localparam int GO_WR_BIT = 0;
   localparam int GO_RD_BIT = 1;
   localparam int EV_DONE = 0;
   localparam int EV_REFUSED = 1;
   localparam int EV_BIPERR = 2;
   localparam int EV_W = 3;
endpackage : nfc_ctrl_pkg

// File: nfc_link_if.sv
// byte-level link between host controller and tag control logic
// the testbench drives boardPull, the level of the board resistor
`timescale 1ns/1ps
interface nfc_link_if;
   logic frmActive;
   logic txValid;
   logic [7:0] txByte;
   logic rxValid;
   logic [7:0] rxByte;
   logic intoOut;
   logic intoOeN;
   logic boardPull;
   logic intoPin;
   // resistor wins only while the device lets go of the pin
   assign intoPin = intoOeN ? boardPull : intoOut;
   modport device (input frmActive, input txValid, input txByte,
                   output rxValid, output rxByte, output intoOut, output intoOeN);
   modport host (output frmActive, output txValid, output txByte,
                 input rxValid, input rxByte, input intoPin);
endinterface : nfc_link_if

// File: nfc_tag_general_control.sv
// tag end: general control register, interrupt flags/enables, link decoder
// assumes link bytes arrive synchronous to clk, one per txValid pulse
// Notes on behaviour
// - low byte at even address, high byte odd
// - restart bit resets settings, link waits, reads 0
// - host waits recovery then rewrites everything
// - radio on runs check; failure flags error
// - host should clear radio before memory writes
// - host avoids writes while radio on
// - interrupt enable low keeps pin floating
// - polarity bit picks active level
// - open drain floats when nothing pending
// - push-pull drives inactive level when idle
// - parity bit switches later frames to checked format
// - check byte is XOR of covered bytes
// - standby only when radio, watchdog, link idle
// - checked write with bad byte is discarded
// - pin shows OR of enabled pending flags
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module nfc_tag_general_control (
   input wire logic clk, // 200 MHz
   input wire logic rst_n, // async, active low
   nfc_link_if.device lnk, // link to host
   input wire logic ndefOk, // result of the message structure check
   input wire logic watchdogOn, // communication watchdog running
   output logic radioOn, // radio interface enabled
   output logic bipMode, // checked framing in force
   output logic standby, // low-power standby entered
   output logic restartBusy // recovering from soft restart
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] ien;
      logic [7:0] flags;
   } regs_type;

   typedef struct packed {
      regs_type r;
      logic [2:0] idx;
      logic [7:0] cmd;
      logic [15:0] addr;
      logic [7:0] d0;
      logic [7:0] d1;
      logic [7:0] acc;
      logic [15:0] busyCnt;
      logic rxValid;
      logic [7:0] rxByte;
      logic intoOut;
      logic intoOeN;
      logic standby;
      logic busy;
   } state_type;

   localparam regs_type REGS_RESET = '{nfc_ctrl_pkg::CTRL_RESET, nfc_ctrl_pkg::IEN_RESET,
                                       nfc_ctrl_pkg::FLAG_RESET};

   state_type q;
   state_type d;

   // ****************************************
   // register byte access
   // ****************************************
   function automatic logic [7:0] readByte(input regs_type r, input logic [15:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         nfc_ctrl_pkg::CTRL_ADDR: begin
            v = r.ctrl;
            v[nfc_ctrl_pkg::RESTART_BIT] = 1'b0;
         end
         nfc_ctrl_pkg::IEN_ADDR: v = r.ien;
         nfc_ctrl_pkg::FLAG_ADDR: v = r.flags;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : readByte

   function automatic regs_type writeByte(input regs_type r, input logic [15:0] a,
                                          input logic [7:0] v, input logic ok);
      regs_type n;
      n = r;
      case (a)
         nfc_ctrl_pkg::CTRL_ADDR: begin
            n.ctrl = v;
            n.ctrl[nfc_ctrl_pkg::RESTART_BIT] = 1'b0;
            // only an off-to-on step runs the structure check
            if (v[nfc_ctrl_pkg::RADIO_BIT] && !r.ctrl[nfc_ctrl_pkg::RADIO_BIT] && !ok) begin
               n.ctrl[nfc_ctrl_pkg::RADIO_BIT] = 1'b0;
               n.flags[nfc_ctrl_pkg::IRQ_NDEF_BIT] = 1'b1;
            end
         end
         nfc_ctrl_pkg::IEN_ADDR: n.ien = v;
         nfc_ctrl_pkg::FLAG_ADDR: n.flags = r.flags & ~v;
         default: n = r;
      endcase
      return n;
   endfunction : writeByte

   function automatic logic isRestart(input logic [15:0] a, input logic [7:0] v);
      return (a == nfc_ctrl_pkg::CTRL_ADDR) && v[nfc_ctrl_pkg::RESTART_BIT];
   endfunction : isRestart

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic bipOn;
      logic isWr;
      logic isRd;
      logic evBip;
      logic restart;
      logic pending;
      logic [7:0] b;
      logic [7:0] rd;
      regs_type keep;
      bipOn = q.r.ctrl[nfc_ctrl_pkg::BIP_BIT];
      isWr = (q.cmd == nfc_ctrl_pkg::CMD_WRITE);
      isRd = (q.cmd == nfc_ctrl_pkg::CMD_READ) || (q.cmd == nfc_ctrl_pkg::CMD_READ_ALT);
      evBip = 1'b0;
      restart = 1'b0;
      pending = 1'b0;
      b = lnk.txByte;
      rd = readByte(q.r, q.addr);
      keep = q.r;
      d = q;
      d.rxValid = 1'b0;
      if (q.busyCnt != 16'h0000) begin
         d.busyCnt = q.busyCnt - 16'h0001;
      end
      if (!lnk.frmActive) begin
         d.idx = nfc_ctrl_pkg::IDX_CMD;
      end else if (lnk.txValid && q.busyCnt == 16'h0000) begin
         if (q.idx != nfc_ctrl_pkg::IDX_LAST) begin
            d.idx = q.idx + 3'h1;
         end
         case (q.idx)
            nfc_ctrl_pkg::IDX_CMD: d.cmd = b;
            nfc_ctrl_pkg::IDX_AHI: begin
               d.addr[15:8] = b;
               d.acc = b;
            end
            nfc_ctrl_pkg::IDX_ALO: begin
               d.addr[7:0] = b;
               d.acc = q.acc ^ b;
            end
            default: begin
               if (isWr && bipOn) begin
                  // checked write: hold both bytes until the check byte
                  if (q.idx == nfc_ctrl_pkg::IDX_D0) begin
                     d.d0 = b;
                     d.acc = q.acc ^ b;
                  end else if (q.idx == nfc_ctrl_pkg::IDX_D1) begin
                     d.d1 = b;
                     d.acc = q.acc ^ b;
                  end else if (q.idx == nfc_ctrl_pkg::IDX_CHK) begin
                     if (b == q.acc) begin
                        keep = writeByte(q.r, q.addr, q.d0, ndefOk);
                        keep = writeByte(keep, q.addr + 16'h0001, q.d1, ndefOk);
                        restart = isRestart(q.addr, q.d0);
                     end else begin
                        evBip = 1'b1;
                     end
                  end
               end else if (isWr) begin
                  keep = writeByte(q.r, q.addr, b, ndefOk);
                  restart = isRestart(q.addr, b);
                  d.addr = q.addr + 16'h0001;
               end else if (isRd && q.idx == nfc_ctrl_pkg::IDX_D0) begin
                  d.acc = q.acc ^ b; // dummy byte is covered too
               end else if (isRd && bipOn) begin
                  d.rxValid = (q.idx <= 3'h6);
                  if (q.idx == 3'h6) begin
                     d.rxByte = q.acc;
                  end else begin
                     d.rxByte = rd;
                     d.acc = q.acc ^ rd;
                     d.addr = q.addr + 16'h0001;
                  end
               end else if (isRd) begin
                  d.rxValid = 1'b1;
                  d.rxByte = rd;
                  d.addr = q.addr + 16'h0001;
               end
            end
         endcase
      end
      d.r = keep;
      if (restart) begin
         d.r = REGS_RESET;
         d.busyCnt = 16'(nfc_ctrl_pkg::RESTART_CYCLES);
         d.idx = nfc_ctrl_pkg::IDX_LAST;
      end
      // hardware set wins over a same-cycle clear
      if (evBip) begin
         d.r.flags[nfc_ctrl_pkg::IRQ_BIP_BIT] = 1'b1;
      end
      pending = |(d.r.flags & d.r.ien);
      d.intoOeN = !(d.r.ctrl[nfc_ctrl_pkg::INTEN_BIT] &&
                    (pending || d.r.ctrl[nfc_ctrl_pkg::PUSHPULL_BIT]));
      d.intoOut = pending ? d.r.ctrl[nfc_ctrl_pkg::POLHIGH_BIT]
                          : !d.r.ctrl[nfc_ctrl_pkg::POLHIGH_BIT];
      d.standby = d.r.ctrl[nfc_ctrl_pkg::STANDBY_BIT] && !d.r.ctrl[nfc_ctrl_pkg::RADIO_BIT]
                  && !watchdogOn && !lnk.frmActive && d.busyCnt == 16'h0000;
      d.busy = d.busyCnt != 16'h0000;
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{r: REGS_RESET, idx: 3'h0, cmd: 8'h00, addr: 16'h0000, d0: 8'h00, d1: 8'h00,
                acc: 8'h00, busyCnt: 16'h0000, rxValid: 1'b0, rxByte: 8'h00,
                intoOut: 1'b1, intoOeN: 1'b1, standby: 1'b0, busy: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign lnk.rxValid = q.rxValid;
   assign lnk.rxByte = q.rxByte;
   assign lnk.intoOut = q.intoOut;
   assign lnk.intoOeN = q.intoOeN;
   assign radioOn = q.r.ctrl[nfc_ctrl_pkg::RADIO_BIT];
   assign bipMode = q.r.ctrl[nfc_ctrl_pkg::BIP_BIT];
   assign standby = q.standby;
   assign restartBusy = q.busy;
endmodule : nfc_tag_general_control

// File: nfc_host_ctrl.sv
// host end: turns register commands into link frames, one word per frame
// assumes a simple strobe bus from software, read data one cycle later
`timescale 1ns/1ps
module nfc_host_ctrl (
   input wire logic clk, // 200 MHz
   input wire logic rst_n, // async, active low
   nfc_link_if.host lnk, // link to tag
   input wire logic [3:0] addr, // register index
   input wire logic [15:0] wdata, // write data
   input wire logic wrStb, // write strobe
   input wire logic rdStb, // read strobe
   output logic [15:0] rdata, // read data, cycle after rdStb
   output logic irq // level, enabled event pending
);
   typedef enum logic [1:0] {
      IDLE = 2'b00,
      SEND = 2'b01,
      RECOVER = 2'b10
   } fsm_type;

   typedef struct packed {
      fsm_type fsm;
      logic [15:0] tgt;
      logic [15:0] wd;
      logic [15:0] rdWord;
      logic isRead;
      logic [2:0] idx;
      logic [1:0] rxCnt;
      logic [7:0] acc;
      logic bipMirror;
      logic radioMirror;
      logic [15:0] waitCnt;
      logic [nfc_ctrl_pkg::EV_W-1:0] ev;
      logic [nfc_ctrl_pkg::EV_W-1:0] ien;
      logic [15:0] rdata;
      logic irq;
      logic frm;
      logic txValid;
      logic [7:0] txByte;
   } state_type;

   state_type q;
   state_type d;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      logic [2:0] last;
      logic [7:0] chk;
      logic [7:0] nb;
      logic [nfc_ctrl_pkg::EV_W-1:0] set;
      last = q.isRead ? (q.bipMirror ? 3'h6 : 3'h5) : (q.bipMirror ? 3'h5 : 3'h4);
      chk = q.tgt[15:8] ^ q.tgt[7:0] ^ q.wd[7:0] ^ q.wd[15:8];
      nb = 8'h00;
      set = '0;
      d = q;
      d.txValid = 1'b0;
      case (q.idx)
         nfc_ctrl_pkg::IDX_AHI: nb = q.tgt[15:8];
         nfc_ctrl_pkg::IDX_ALO: nb = q.tgt[7:0];
         nfc_ctrl_pkg::IDX_D0: nb = q.isRead ? nfc_ctrl_pkg::DUMMY_BYTE : q.wd[7:0];
         nfc_ctrl_pkg::IDX_D1: nb = q.isRead ? 8'h00 : q.wd[15:8];
         nfc_ctrl_pkg::IDX_CHK: nb = q.isRead ? 8'h00 : chk;
         default: nb = 8'h00;
      endcase
      case (q.fsm)
         IDLE: begin
            if (wrStb && addr == nfc_ctrl_pkg::H_CMD &&
                (wdata[nfc_ctrl_pkg::GO_WR_BIT] || wdata[nfc_ctrl_pkg::GO_RD_BIT])) begin
               if (wdata[nfc_ctrl_pkg::GO_WR_BIT] && q.radioMirror &&
                   q.tgt != nfc_ctrl_pkg::CTRL_ADDR) begin
                  set[nfc_ctrl_pkg::EV_REFUSED] = 1'b1;
               end else begin
                  d.isRead = !wdata[nfc_ctrl_pkg::GO_WR_BIT];
                  d.fsm = SEND;
                  d.frm = 1'b1;
                  d.txValid = 1'b1;
                  d.txByte = wdata[nfc_ctrl_pkg::GO_WR_BIT] ? nfc_ctrl_pkg::CMD_WRITE
                                                            : nfc_ctrl_pkg::CMD_READ;
                  d.idx = nfc_ctrl_pkg::IDX_AHI;
                  d.rxCnt = 2'h0;
                  d.acc = q.tgt[15:8] ^ q.tgt[7:0] ^ nfc_ctrl_pkg::DUMMY_BYTE;
               end
            end
         end
         SEND: begin
            if (q.idx <= last) begin
               d.txValid = 1'b1;
               d.txByte = nb;
               d.idx = q.idx + 3'h1;
            end else begin
               // last reply lands just after the close and is still taken below
               d.frm = 1'b0;
               d.fsm = IDLE;
               set[nfc_ctrl_pkg::EV_DONE] = 1'b1;
               if (!q.isRead && q.tgt == nfc_ctrl_pkg::CTRL_ADDR) begin
                  d.bipMirror = q.wd[nfc_ctrl_pkg::BIP_BIT];
                  d.radioMirror = q.wd[nfc_ctrl_pkg::RADIO_BIT];
                  if (q.wd[nfc_ctrl_pkg::RESTART_BIT]) begin
                     d.bipMirror = 1'b0;
                     d.radioMirror = 1'b0;
                     d.waitCnt = 16'(nfc_ctrl_pkg::RESTART_CYCLES);
                     d.fsm = RECOVER;
                     set[nfc_ctrl_pkg::EV_DONE] = 1'b0;
                  end
               end
            end
         end
         RECOVER: begin
            d.waitCnt = q.waitCnt - 16'h0001;
            if (q.waitCnt == 16'h0001) begin
               d.fsm = IDLE;
               set[nfc_ctrl_pkg::EV_DONE] = 1'b1;
            end
         end
         default: d.fsm = IDLE;
      endcase
      if (lnk.rxValid) begin
         d.rxCnt = q.rxCnt + 2'h1;
         if (q.rxCnt == 2'h0) begin
            d.rdWord[7:0] = lnk.rxByte;
            d.acc = q.acc ^ lnk.rxByte;
         end else if (q.rxCnt == 2'h1) begin
            d.rdWord[15:8] = lnk.rxByte;
            d.acc = q.acc ^ lnk.rxByte;
         end else if (lnk.rxByte != q.acc) begin
            set[nfc_ctrl_pkg::EV_BIPERR] = 1'b1;
         end
      end
      if (wrStb) begin
         case (addr)
            nfc_ctrl_pkg::H_ADDR: d.tgt = (q.fsm == IDLE) ? wdata : q.tgt;
            nfc_ctrl_pkg::H_WDATA: d.wd = (q.fsm == IDLE) ? wdata : q.wd;
            nfc_ctrl_pkg::H_IRQCLR: d.ev = q.ev & ~wdata[nfc_ctrl_pkg::EV_W-1:0];
            nfc_ctrl_pkg::H_IRQEN: d.ien = wdata[nfc_ctrl_pkg::EV_W-1:0];
            default: d.ev = q.ev;
         endcase
      end
      d.ev = d.ev | set;
      d.irq = |(d.ev & d.ien);
      d.rdata = 16'h0000;
      if (rdStb) begin
         case (addr)
            nfc_ctrl_pkg::H_ADDR: d.rdata = q.tgt;
            nfc_ctrl_pkg::H_WDATA: d.rdata = q.wd;
            nfc_ctrl_pkg::H_STAT: d.rdata = {12'h000, lnk.intoPin, q.bipMirror,
                                             q.radioMirror, q.fsm != IDLE};
            nfc_ctrl_pkg::H_RDATA: d.rdata = q.rdWord;
            nfc_ctrl_pkg::H_IRQST: d.rdata = {13'h0000, q.ev};
            nfc_ctrl_pkg::H_IRQEN: d.rdata = {13'h0000, q.ien};
            default: d.rdata = 16'h0000;
         endcase
      end
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '{fsm: IDLE, tgt: 16'h0000, wd: 16'h0000, rdWord: 16'h0000, isRead: 1'b0,
                idx: 3'h0, rxCnt: 2'h0, acc: 8'h00, bipMirror: 1'b0, radioMirror: 1'b0,
                waitCnt: 16'h0000, ev: '0, ien: '0, rdata: 16'h0000, irq: 1'b0,
                frm: 1'b0, txValid: 1'b0, txByte: 8'h00};
      end else begin
         q <= d;
      end
   end

   assign lnk.frmActive = q.frm;
   assign lnk.txValid = q.txValid;
   assign lnk.txByte = q.txByte;
   assign rdata = q.rdata;
   assign irq = q.irq;
endmodule : nfc_host_ctrl

// File: nfc_link_sva.sv
// checker for the link wires between the host controller and the tag
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/1ps
module nfc_link_sva (
   input wire logic clk, // link clock
   input wire logic rst_n, // async, active low
   input wire logic frmActive, // frame level
   input wire logic txValid, // host byte strobe
   input wire logic [7:0] txByte, // host byte
   input wire logic rxValid, // tag byte strobe
   input wire logic intoOut, // pin level when driven
   input wire logic intoOeN // pin released when high
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ****************************************
   // framing
   // ****************************************
   a_tx_in_frame: assert property (txValid |-> frmActive)
      else $error("host byte outside a frame");
   a_frame_cmd: assert property ($rose(frmActive) |-> txValid &&
      (txByte == nfc_ctrl_pkg::CMD_WRITE || txByte == nfc_ctrl_pkg::CMD_READ))
      else $error("frame does not open with a command byte");
   a_frame_len: assert property ($rose(frmActive) |-> txValid [*5])
      else $error("frame shorter than five back to back bytes");
   a_write_silent: assert property ($rose(frmActive) &&
      txByte == nfc_ctrl_pkg::CMD_WRITE |-> !rxValid [*7])
      else $error("tag answered a write frame");
   // address and dummy polls get no answer, the first data poll does
   a_read_reply: assert property ($rose(frmActive) &&
      txByte == nfc_ctrl_pkg::CMD_READ |-> !rxValid [*5] ##1 rxValid)
      else $error("read answer missing or early");
   a_rx_after_poll: assert property (rxValid |-> $past(txValid))
      else $error("tag byte without a poll one cycle before");
   a_rx_in_frame: assert property (rxValid |-> $past(frmActive))
      else $error("tag byte outside a frame");
   // ****************************************
   // interrupt pin
   // ****************************************
   // pin state only moves as a result of a received byte
   a_pin_cause: assert property ($changed(intoOeN) || $changed(intoOut) |->
      $past(txValid) || $past(txValid, 2) || $past(txValid, 3))
      else $error("interrupt pin changed with no byte received");
endmodule : nfc_link_sva

// File: tb_nfc_tag_general_control.sv
// bench: host controller and tag joined back to back, plus a second tag
// driven by hand with a broken check byte; model kept in plain ints
`timescale 1ns/1ps
module tb_nfc_tag_general_control;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wrStb = 1'b0;
   logic rdStb = 1'b0;
   logic ndefOk = 1'b0;
   logic watchdogOn = 1'b0;
   logic [15:0] rdata, v;
   logic irq, radioOn, bipMode, standby, restartBusy;
   logic radioOn2, bipMode2, standby2, restartBusy2;
   int error_cnt = 0;
   int num_checks = 0;
   int mCtrl = 0;
   int mIen = 0;
   int mFlag = 0;
   logic [7:0] rx2 = 8'h00;
   always @(posedge clk) begin
      if (lnk2.rxValid) rx2 <= lnk2.rxByte;
   end
   nfc_link_if lnk ();
   nfc_link_if lnk2 ();
   nfc_tag_general_control nfc_tag_general_control_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk),
      .ndefOk(ndefOk), .watchdogOn(watchdogOn), .radioOn(radioOn), .bipMode(bipMode),
      .standby(standby), .restartBusy(restartBusy));
   nfc_tag_general_control nfc_tag_general_control_inst2 (.clk(clk), .rst_n(rst_n),
      .lnk(lnk2), .ndefOk(ndefOk), .watchdogOn(watchdogOn), .radioOn(radioOn2),
      .bipMode(bipMode2), .standby(standby2), .restartBusy(restartBusy2));
   nfc_host_ctrl nfc_host_ctrl_inst (.clk(clk), .rst_n(rst_n), .lnk(lnk), .addr(addr),
      .wdata(wdata), .wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .irq(irq));
   nfc_link_sva nfc_link_sva_inst (.clk(clk), .rst_n(rst_n), .frmActive(lnk.frmActive),
      .txValid(lnk.txValid), .txByte(lnk.txByte), .rxValid(lnk.rxValid),
      .intoOut(lnk.intoOut), .intoOeN(lnk.intoOeN));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ****************************************
   // compare, bus and link tasks
   // ****************************************
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic chkb(input string nm, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : chkb
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wrStb <= 1'b1;
      @(posedge clk);
      wrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rdStb <= 1'b1;
      @(posedge clk);
      rdStb <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   // bounded poll; a restart keeps the host busy for the recovery time
   task automatic waitIdle();
      logic [15:0] s;
      for (int i = 0; i < 400; i++) begin
         rd(nfc_ctrl_pkg::H_STAT, s);
         if (s[0] === 1'b0) break;
      end
      chkb("busy", 1'b0, s[0]);
   endtask : waitIdle
   task automatic devWr(input logic [15:0] a, input logic [15:0] d);
      wr(nfc_ctrl_pkg::H_ADDR, a);
      wr(nfc_ctrl_pkg::H_WDATA, d);
      wr(nfc_ctrl_pkg::H_CMD, 16'h0001);
      waitIdle();
   endtask : devWr
   task automatic devRd(input logic [15:0] a, input logic [15:0] e);
      wr(nfc_ctrl_pkg::H_ADDR, a);
      wr(nfc_ctrl_pkg::H_CMD, 16'h0002);
      waitIdle();
      rd(nfc_ctrl_pkg::H_RDATA, v);
      chk("tag word", e, v);
   endtask : devRd
   function automatic logic pinExp(input logic pull);
      if (mCtrl[2] == 0) return pull;
      if ((mFlag & mIen & 8'hFF) != 0) return mCtrl[3];
      if (mCtrl[4]) return !mCtrl[3];
      return pull;
   endfunction : pinExp
   task automatic checkPin();
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         lnk.boardPull <= 1'($urandom);
         @(posedge clk);
         #1;
         chkb("intoPin", pinExp(lnk.boardPull), lnk.intoPin);
      end
   endtask : checkPin
   task automatic frame(input logic [47:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         lnk2.frmActive <= 1'b1;
         lnk2.txValid <= 1'b1;
         lnk2.txByte <= b[47 - 8 * i -: 8];
      end
      @(posedge clk);
      lnk2.frmActive <= 1'b0;
      lnk2.txValid <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
   endtask : frame
   task automatic give_verdict();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      #200000;
      error_cnt++;
      give_verdict();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      lnk.boardPull = 1'b1;
      lnk2.boardPull = 1'b1;
      lnk2.frmActive = 1'b0;
      lnk2.txValid = 1'b0;
      lnk2.txByte = 8'h00;
      void'($urandom(40));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      devRd(nfc_ctrl_pkg::CTRL_ADDR, 16'h0000);
      devRd(nfc_ctrl_pkg::IEN_ADDR, 16'h0000);
      devWr(nfc_ctrl_pkg::CTRL_ADDR, 16'hFF80);
      devRd(nfc_ctrl_pkg::CTRL_ADDR, 16'h0080);
      for (int p = 0; p < 2; p++) begin
         for (int m = 0; m < 8; m++) begin
            mCtrl = m << 2;
            devWr(nfc_ctrl_pkg::CTRL_ADDR, mCtrl[15:0]);
            checkPin();
         end
         // failed structure check raises the error flag, radio stays off
         mIen = 32;
         devWr(nfc_ctrl_pkg::IEN_ADDR, 16'h0020);
         mCtrl = 6;
         mFlag = 32;
         devWr(nfc_ctrl_pkg::CTRL_ADDR, 16'h0006);
         chkb("radioOn", 1'b0, radioOn);
         devRd(nfc_ctrl_pkg::FLAG_ADDR, 16'h0020);
         checkPin();
      end
      mCtrl = 20;
      devWr(nfc_ctrl_pkg::CTRL_ADDR, 16'h0014);
      devWr(nfc_ctrl_pkg::FLAG_ADDR, 16'h0020);
      mFlag = 0;
      devRd(nfc_ctrl_pkg::FLAG_ADDR, 16'h0000);
      checkPin();
      wr(nfc_ctrl_pkg::H_IRQEN, 16'h0002);
      ndefOk <= 1'b1;
      devWr(nfc_ctrl_pkg::CTRL_ADDR, 16'h0002);
      chkb("radioOn", 1'b1, radioOn);
      devWr(nfc_ctrl_pkg::IEN_ADDR, 16'h0000);
      chkb("irq", 1'b1, irq);
      wr(nfc_ctrl_pkg::H_IRQCLR, 16'h0002);
      repeat (2) @(posedge clk);
      chkb("irq", 1'b0, irq);
      devWr(nfc_ctrl_pkg::CTRL_ADDR, 16'h0040);
      chkb("radioOn", 1'b0, radioOn);
      chkb("standby", 1'b1, standby);
      watchdogOn <= 1'b1;
      repeat (3) @(posedge clk);
      chkb("standby", 1'b0, standby);
      watchdogOn <= 1'b0;
      devWr(nfc_ctrl_pkg::CTRL_ADDR, 16'h0042);
      chkb("standby", 1'b0, standby);
      devWr(nfc_ctrl_pkg::CTRL_ADDR, 16'h0020);
      chkb("bipMode", 1'b1, bipMode);
      mIen = $urandom & 8'hFF;
      devWr(nfc_ctrl_pkg::IEN_ADDR, {8'hA5, mIen[7:0]});
      devRd(nfc_ctrl_pkg::IEN_ADDR, mIen[15:0]);
      rd(nfc_ctrl_pkg::H_IRQST, v);
      chkb("read check error", 1'b0, v[2]);
      wr(nfc_ctrl_pkg::H_ADDR, nfc_ctrl_pkg::CTRL_ADDR);
      wr(nfc_ctrl_pkg::H_WDATA, 16'h0001);
      wr(nfc_ctrl_pkg::H_CMD, 16'h0001);
      repeat (12) @(posedge clk);
      chkb("restartBusy", 1'b1, restartBusy);
      waitIdle();
      chkb("restartBusy", 1'b0, restartBusy);
      chkb("bipMode", 1'b0, bipMode);
      devRd(nfc_ctrl_pkg::CTRL_ADDR, 16'h0000);
      devRd(nfc_ctrl_pkg::IEN_ADDR, 16'h0000);
      frame(48'h02FFFE200000, 5);
      chkb("bipMode2", 1'b1, bipMode2);
      frame(48'h02FFFE6000AA, 6);
      chkb("standby2", 1'b0, standby2);
      frame(48'h02FFFE600061, 6);
      chkb("standby2", 1'b1, standby2);
      frame(48'h0BFFFE000000, 5);
      chk("tag2 reply", 16'h0060, {8'h00, rx2});
      give_verdict();
   end
endmodule : tb_nfc_tag_general_control
